// ==== rtl/cmp_status_pkg.sv ====
`default_nettype none
package cmp_status_pkg;

  // ==========================================================
  // Register offsets (byte order select = 0)
  localparam logic [4:0] OFF_MAIN_STATUS = 5'h00;
  localparam logic [4:0] OFF_SHARED_LO = 5'h0a;
  localparam logic [4:0] OFF_SHARED_HI = 5'h0b;
  localparam logic [4:0] OFF_FAULT_STATUS = 5'h0c;
  localparam logic [4:0] OFF_IRQ_STATUS_LOW = 5'h0e;
  localparam logic [4:0] OFF_IRQ_STATUS_HIGH = 5'h0f;
  localparam logic [4:0] OFF_COMMAND_LOW = 5'h10;
  localparam logic [4:0] OFF_COMMAND_HIGH = 5'h11;
  localparam logic [4:0] OFF_RECORD_LENGTH_BYTE2 = 5'h14;
  localparam logic [4:0] OFF_RECORD_LENGTH_BYTE3 = 5'h15;
  localparam logic [4:0] OFF_RECORD_LENGTH_BYTE0 = 5'h16;
  localparam logic [4:0] OFF_RECORD_LENGTH_BYTE1 = 5'h17;
  localparam logic [4:0] OFF_OUTPUT_OFF_COUNT_BYTE2 = 5'h18;
  localparam logic [4:0] OFF_OUTPUT_OFF_COUNT_BYTE3 = 5'h19;
  localparam logic [4:0] OFF_OUTPUT_OFF_COUNT_BYTE0 = 5'h1a;
  localparam logic [4:0] OFF_OUTPUT_OFF_COUNT_BYTE1 = 5'h1b;
  localparam logic [4:0] OFF_FAULT_MASK = 5'h1c;
  localparam logic [4:0] OFF_IRQ_MASK_LOW = 5'h1e;
  localparam logic [4:0] OFF_IRQ_MASK_HIGH = 5'h1f;

  // ==========================================================
  // Main status bit positions
  localparam int BIT_BUSY = 7;
  localparam int BIT_PAUSED = 6;
  localparam int BIT_OUT_OFF = 5;
  localparam int BIT_BYPASS = 4;
  localparam int BIT_EXPAND = 3;
  localparam int BIT_ANY_IRQ = 2;
  localparam int BIT_ANY_FAULT = 1;
  localparam int BIT_DONE = 0;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_COMMAND_HIGH_CMD = 8'ha0;

  // ==========================================================
  // Command codes written to command_low
  localparam logic [7:0] CMD_SEL_PORT_A = 8'h01;
  localparam logic [7:0] CMD_SEL_PORT_B = 8'h02;
  localparam logic [7:0] CMD_RESET = 8'h10;
  localparam logic [7:0] CMD_PAUSE = 8'h11;
  localparam logic [7:0] CMD_RESUME = 8'h12;
  localparam logic [7:0] CMD_START_COMP = 8'h20;
  localparam logic [7:0] CMD_START_COMP_BYPASS = 8'h21;
  localparam logic [7:0] CMD_START_DECOMP = 8'h22;
  localparam logic [7:0] CMD_START_DECOMP_BYPASS = 8'h23;
  localparam logic [7:0] CMD_START_DECOMP_OUT_OFF = 8'h24;

  // ==========================================================
  // Timing
  localparam int REFRESH_CYCLES = 40;
  localparam logic [5:0] REFRESH_LOAD = 6'(REFRESH_CYCLES - 1);

endpackage
`default_nettype wire

// ==== rtl/cmp_status_regs.sv ====
// Overview of operation
// [RULE_01] Byte order select one swaps each even and odd register address.
// [RULE_02] Without a selection command, shared addresses show counts, faults, irqs, status.
// [RULE_03] Port A select shows FIFO control; port B select shows compressed bytes.
// [RULE_04] Length, off count and masks clear on reset only, survive new transfer.
// [RULE_05] Irq, fault, port B count, FIFO control, compressed bytes clear on every reset and new transfer.
// [RULE_06] Main status reads zero after resets and ignores host writes.
// [RULE_07] Flags active at pause stay active until resume, reset or new transfer.
// [RULE_08] Busy sets on start, clears on done, unmasked fault or reset.
// [RULE_09] Paused high while paused; clears on resume, reset or new transfer.
// [RULE_10] Output off flag follows port A output disable; clears on reset or start.
// [RULE_11] Bypass sets on bypass starts; clears on other starts, fault, done, reset.
// [RULE_12] Expand tracks port B count above port A count while busy after a non-bypass compress start.
// [RULE_13] Any irq high while an unmasked irq is pending.
// [RULE_14] Any fault sets on unmasked fault; clears on start or reset.
// [RULE_15] Done sets on completion; clears on start or reset.
// [RULE_16] Pause refreshes prefetched copies within 40 cycles before paused sets.
// [RULE_17] Reset command loads command_high with 0xa0; hardware reset leaves zero.
// [RULE_18] Reserved addresses read zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none
module cmp_status_regs (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [4:0] host_addr,
  input wire logic host_wr_en,
  input wire logic host_rd_en,
  input wire logic [7:0] host_wdata,
  input wire logic byte_order_select,
  input wire logic op_done,
  input wire logic [7:0] fault_event,
  input wire logic [15:0] irq_event,
  input wire logic port_a_out_disabled,
  input wire logic [31:0] port_a_count,
  input wire logic [31:0] port_b_count,
  input wire logic [31:0] compressed_bytes,
  output logic [7:0] host_rdata,
  output logic [7:0] engine_cmd,
  output logic engine_cmd_valid,
  output logic engine_paused,
  output logic [31:0] record_length,
  output logic [31:0] output_off_count,
  output logic [7:0] port_a_fifo_control,
  output logic [7:0] command_high
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [7:0] cmd_lo;
    logic [7:0] cmd_hi;
    logic [31:0] rec_len;
    logic [31:0] off_cnt;
    logic [7:0] fault_mask;
    logic [15:0] irq_mask;
    logic [7:0] fault_stat;
    logic [15:0] irq_stat;
    logic [7:0] fifo_ctl;
    logic [15:0] btc_copy;
    logic [15:0] cbd_copy;
    logic busy;
    logic paused;
    logic out_off;
    logic bypass;
    logic expand;
    logic any_irq;
    logic any_fault;
    logic done;
    logic comp_mode;
    logic refreshing;
    logic [5:0] refresh_cnt;
    logic [7:0] rdata;
    logic [7:0] eng_cmd;
    logic eng_valid;
  } state_t;

  localparam state_t STATE_RESET = '0;

  state_t s;
  state_t n;
  logic [1:0] rst_sync_r;
  logic rst_n;
  logic [4:0] a;
  logic sel_a;
  logic sel_b;
  logic wr_cmd;
  logic [7:0] w;
  logic [7:0] unmasked_fault;
  logic [15:0] irq_clr;
  logic [7:0] flags;
  logic [7:0] main_status;
  logic is_start;

  // ==========================================================
  // Reset release
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  assign main_status = {s.busy, s.paused, s.out_off, s.bypass,
                        s.expand, s.any_irq, s.any_fault, s.done};

  // ==========================================================
  // Next state
  always_comb begin
    n = s;
    w = host_wdata;
    n.eng_valid = 1'b0;
    a = host_addr ^ {4'h0, byte_order_select}; // RULE_01
    sel_a = (s.cmd_lo == cmp_status_pkg::CMD_SEL_PORT_A);
    sel_b = (s.cmd_lo == cmp_status_pkg::CMD_SEL_PORT_B);
    wr_cmd = host_wr_en && (a == cmp_status_pkg::OFF_COMMAND_LOW);
    is_start = (w == cmp_status_pkg::CMD_START_COMP) ||
               (w == cmp_status_pkg::CMD_START_COMP_BYPASS) ||
               (w == cmp_status_pkg::CMD_START_DECOMP) ||
               (w == cmp_status_pkg::CMD_START_DECOMP_BYPASS) ||
               (w == cmp_status_pkg::CMD_START_DECOMP_OUT_OFF);
    irq_clr = 16'h0000;
    // Host writes; unlisted and reserved addresses fall through untouched
    if (host_wr_en) begin
      case (a)
        cmp_status_pkg::OFF_SHARED_LO: begin
          if (sel_a) begin
            n.fifo_ctl = w; // RULE_03
          end
        end
        cmp_status_pkg::OFF_IRQ_STATUS_LOW: begin
          if (!sel_a && !sel_b) begin
            irq_clr[7:0] = w;
          end
        end
        cmp_status_pkg::OFF_IRQ_STATUS_HIGH: begin
          if (!sel_a && !sel_b) begin
            irq_clr[15:8] = w;
          end
        end
        cmp_status_pkg::OFF_COMMAND_HIGH: n.cmd_hi = w;
        cmp_status_pkg::OFF_RECORD_LENGTH_BYTE0: n.rec_len[7:0] = w;
        cmp_status_pkg::OFF_RECORD_LENGTH_BYTE1: n.rec_len[15:8] = w;
        cmp_status_pkg::OFF_RECORD_LENGTH_BYTE2: n.rec_len[23:16] = w;
        cmp_status_pkg::OFF_RECORD_LENGTH_BYTE3: n.rec_len[31:24] = w;
        cmp_status_pkg::OFF_OUTPUT_OFF_COUNT_BYTE0: n.off_cnt[7:0] = w;
        cmp_status_pkg::OFF_OUTPUT_OFF_COUNT_BYTE1: n.off_cnt[15:8] = w;
        cmp_status_pkg::OFF_OUTPUT_OFF_COUNT_BYTE2: n.off_cnt[23:16] = w;
        cmp_status_pkg::OFF_OUTPUT_OFF_COUNT_BYTE3: n.off_cnt[31:24] = w;
        cmp_status_pkg::OFF_FAULT_MASK: n.fault_mask = w;
        cmp_status_pkg::OFF_IRQ_MASK_LOW: n.irq_mask[7:0] = w;
        cmp_status_pkg::OFF_IRQ_MASK_HIGH: n.irq_mask[15:8] = w;
        default: begin
        end
      endcase
    end
    // Event beats the clear in the same cycle
    n.irq_stat = (s.irq_stat & ~irq_clr) | irq_event;
    n.fault_stat = s.fault_stat | fault_event;
    // A set mask bit lets the fault stop the transfer
    unmasked_fault = fault_event & s.fault_mask;

    // Prefetched copies frozen while paused so host reads are coherent
    if (!s.paused) begin
      n.btc_copy = port_b_count[15:0];
      n.cbd_copy = compressed_bytes[15:0];
    end
    if (s.refreshing) begin
      if (s.refresh_cnt == 6'h00) begin
        n.refreshing = 1'b0;
        n.paused = 1'b1; // RULE_16 RULE_09
        n.btc_copy = port_b_count[15:0];
        n.cbd_copy = compressed_bytes[15:0];
      end else begin
        n.refresh_cnt = s.refresh_cnt - 6'h01;
      end
    end

    // Flag candidates before pause hold
    flags = main_status;
    if (op_done) begin
      flags[cmp_status_pkg::BIT_DONE] = 1'b1; // RULE_15
      flags[cmp_status_pkg::BIT_BUSY] = 1'b0; // RULE_08
      flags[cmp_status_pkg::BIT_BYPASS] = 1'b0; // RULE_11
    end
    if (|unmasked_fault) begin
      flags[cmp_status_pkg::BIT_ANY_FAULT] = 1'b1; // RULE_14
      flags[cmp_status_pkg::BIT_BUSY] = 1'b0; // RULE_08
      flags[cmp_status_pkg::BIT_BYPASS] = 1'b0; // RULE_11
    end
    flags[cmp_status_pkg::BIT_OUT_OFF] = port_a_out_disabled; // RULE_10
    flags[cmp_status_pkg::BIT_EXPAND] = s.comp_mode && s.busy &&
                                        (port_b_count > port_a_count); // RULE_12

    // Interrupt pauses a running transfer; paused only after the refresh
    if (s.busy && s.any_irq && !s.paused && !s.refreshing) begin
      n.refreshing = 1'b1;
      n.refresh_cnt = cmp_status_pkg::REFRESH_LOAD; // RULE_16
    end

    // Commands
    if (wr_cmd) begin
      n.cmd_lo = w;
      n.eng_cmd = w;
      n.eng_valid = 1'b1;
      if (w == cmp_status_pkg::CMD_PAUSE) begin
        if (s.busy && !s.paused && !s.refreshing) begin
          n.refreshing = 1'b1;
          n.refresh_cnt = cmp_status_pkg::REFRESH_LOAD; // RULE_16
        end
      end else if (w == cmp_status_pkg::CMD_RESUME) begin
        n.paused = 1'b0; // RULE_09
        n.refreshing = 1'b0;
      end else if (is_start) begin
        // New transfer: per-transfer state clears, setup registers survive
        n.irq_stat = '0; // RULE_05
        n.fault_stat = '0; // RULE_05
        n.fifo_ctl = cmp_status_pkg::RST_ZERO; // RULE_05
        n.btc_copy = '0; // RULE_05
        n.cbd_copy = '0; // RULE_05
        n.paused = 1'b0; // RULE_09
        n.refreshing = 1'b0;
        n.comp_mode = (w == cmp_status_pkg::CMD_START_COMP);
        flags = 8'h00; // RULE_15 RULE_14 RULE_12 RULE_10
        flags[cmp_status_pkg::BIT_BUSY] = 1'b1; // RULE_08
        flags[cmp_status_pkg::BIT_BYPASS] =
          (w == cmp_status_pkg::CMD_START_COMP_BYPASS) ||
          (w == cmp_status_pkg::CMD_START_DECOMP_BYPASS); // RULE_11
      end
    end

    // Held flags only clear once paused drops: resume, reset or new transfer
    if (s.paused && n.paused) begin
      flags = flags | main_status; // RULE_07
    end
    {n.busy, n.out_off, n.bypass, n.expand, n.any_fault, n.done} =
      {flags[cmp_status_pkg::BIT_BUSY], flags[cmp_status_pkg::BIT_OUT_OFF],
       flags[cmp_status_pkg::BIT_BYPASS], flags[cmp_status_pkg::BIT_EXPAND],
       flags[cmp_status_pkg::BIT_ANY_FAULT], flags[cmp_status_pkg::BIT_DONE]};
    n.any_irq = (|(n.irq_stat & n.irq_mask)) ||
                (s.paused && n.paused && s.any_irq); // RULE_13 RULE_07

    // Reset command: like hardware reset apart from command_high and the engine command outputs
    if (wr_cmd && (w == cmp_status_pkg::CMD_RESET)) begin
      n = STATE_RESET; // RULE_04 RULE_05 RULE_06
      n.cmd_hi = cmp_status_pkg::RST_COMMAND_HIGH_CMD; // RULE_17
      n.eng_cmd = w;
      n.eng_valid = 1'b1;
    end

    // Registered read; main status has no write path
    if (host_rd_en) begin
      n.rdata = cmp_status_pkg::RST_ZERO; // RULE_18
      case (a)
        cmp_status_pkg::OFF_MAIN_STATUS: begin
          if (!sel_a && !sel_b) begin
            n.rdata = main_status; // RULE_06 RULE_02
          end
        end
        cmp_status_pkg::OFF_SHARED_LO: begin
          if (sel_a) begin
            n.rdata = s.fifo_ctl; // RULE_03
          end else if (sel_b) begin
            n.rdata = s.cbd_copy[7:0]; // RULE_03
          end else begin
            n.rdata = s.btc_copy[7:0]; // RULE_02
          end
        end
        cmp_status_pkg::OFF_SHARED_HI: begin
          if (sel_b) begin
            n.rdata = s.cbd_copy[15:8]; // RULE_03
          end else if (!sel_a) begin
            n.rdata = s.btc_copy[15:8]; // RULE_02
          end
        end
        cmp_status_pkg::OFF_FAULT_STATUS: begin
          if (!sel_a && !sel_b) begin
            n.rdata = s.fault_stat; // RULE_02
          end
        end
        cmp_status_pkg::OFF_IRQ_STATUS_LOW: begin
          if (!sel_a && !sel_b) begin
            n.rdata = s.irq_stat[7:0]; // RULE_02
          end
        end
        cmp_status_pkg::OFF_IRQ_STATUS_HIGH: begin
          if (!sel_a && !sel_b) begin
            n.rdata = s.irq_stat[15:8]; // RULE_02
          end
        end
        cmp_status_pkg::OFF_COMMAND_LOW: n.rdata = s.cmd_lo;
        cmp_status_pkg::OFF_COMMAND_HIGH: n.rdata = s.cmd_hi;
        cmp_status_pkg::OFF_RECORD_LENGTH_BYTE0: n.rdata = s.rec_len[7:0];
        cmp_status_pkg::OFF_RECORD_LENGTH_BYTE1: n.rdata = s.rec_len[15:8];
        cmp_status_pkg::OFF_RECORD_LENGTH_BYTE2: n.rdata = s.rec_len[23:16];
        cmp_status_pkg::OFF_RECORD_LENGTH_BYTE3: n.rdata = s.rec_len[31:24];
        cmp_status_pkg::OFF_OUTPUT_OFF_COUNT_BYTE0: n.rdata = s.off_cnt[7:0];
        cmp_status_pkg::OFF_OUTPUT_OFF_COUNT_BYTE1: n.rdata = s.off_cnt[15:8];
        cmp_status_pkg::OFF_OUTPUT_OFF_COUNT_BYTE2: n.rdata = s.off_cnt[23:16];
        cmp_status_pkg::OFF_OUTPUT_OFF_COUNT_BYTE3: n.rdata = s.off_cnt[31:24];
        cmp_status_pkg::OFF_FAULT_MASK: n.rdata = s.fault_mask;
        cmp_status_pkg::OFF_IRQ_MASK_LOW: n.rdata = s.irq_mask[7:0];
        cmp_status_pkg::OFF_IRQ_MASK_HIGH: n.rdata = s.irq_mask[15:8];
        default: n.rdata = cmp_status_pkg::RST_ZERO; // RULE_18
      endcase
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= STATE_RESET; // RULE_04 RULE_05 RULE_06 RULE_17
    end else begin
      s <= n;
    end
  end

  assign host_rdata = s.rdata;
  assign engine_cmd = s.eng_cmd;
  assign engine_cmd_valid = s.eng_valid;
  assign engine_paused = s.paused;
  assign record_length = s.rec_len;
  assign output_off_count = s.off_cnt;
  assign port_a_fifo_control = s.fifo_ctl;
  assign command_high = s.cmd_hi;

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  property p_swap;
    host_rd_en && byte_order_select && (host_addr == 5'h11) |=> host_rdata == $past(s.cmd_lo);
  endproperty
  a_swap: assert property (p_swap) else $error("byte order swap wrong"); // RULE_01

  property p_sel_b_map;
    host_rd_en && !host_wr_en && sel_b && (a == 5'h0a) |=> host_rdata == $past(s.cbd_copy[7:0]);
  endproperty
  a_sel_b_map: assert property (p_sel_b_map) else $error("port B alias wrong"); // RULE_03

  property p_reset_cmd;
    wr_cmd && (w == 8'h10) |=> (s.cmd_hi == 8'ha0) && (main_status == 8'h00)
      && (s.rec_len == 32'h0) && (s.irq_mask == 16'h0);
  endproperty
  a_reset_cmd: assert property (p_reset_cmd) else $error("reset command values wrong"); // RULE_17

  property p_start_keeps;
    wr_cmd && is_start |=> s.busy && (s.irq_stat == 16'h0) && (s.fifo_ctl == 8'h00)
      && (s.rec_len == $past(s.rec_len)) && !s.paused && !s.done;
  endproperty
  a_start_keeps: assert property (p_start_keeps) else $error("new transfer values wrong"); // RULE_05

  property p_refresh_bound;
    $rose(s.refreshing) |-> !s.paused ##[1:40] (s.paused || !s.refreshing);
  endproperty
  a_refresh_bound: assert property (p_refresh_bound) else $error("pause refresh too slow"); // RULE_16

  property p_pause_hold;
    s.paused && s.done && !(wr_cmd && (w == 8'h12 || w == 8'h10 || is_start)) |=> s.done;
  endproperty
  a_pause_hold: assert property (p_pause_hold) else $error("flag dropped while paused"); // RULE_07

  property p_any_irq;
    !s.paused |-> s.any_irq == (|(s.irq_stat & s.irq_mask));
  endproperty
  a_any_irq: assert property (p_any_irq) else $error("any irq mismatch"); // RULE_13

  property p_fault_stop;
    !s.paused && !wr_cmd && (|(fault_event & s.fault_mask)) |=> !s.busy && s.any_fault
      && !s.bypass;
  endproperty
  a_fault_stop: assert property (p_fault_stop) else $error("unmasked fault not taken"); // RULE_14

  property p_done;
    !s.paused && !wr_cmd && op_done |=> s.done && !s.busy;
  endproperty
  a_done: assert property (p_done) else $error("done not set"); // RULE_15

  property p_reserved;
    host_rd_en && (a == 5'h12 || a == 5'h0d || a == 5'h1d) |=> host_rdata == 8'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved read not zero"); // RULE_18

endmodule
`default_nettype wire

// ==== test/host_cpu_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module host_cpu_model (
  input wire logic core_clk,
  output logic [4:0] host_addr,
  output logic host_wr_en,
  output logic host_rd_en,
  output logic [7:0] host_wdata,
  input wire logic [7:0] host_rdata
);
  // ==========================================================
  // Idle bus
  initial begin
    host_addr = 5'h00;
    host_wr_en = 1'b0;
    host_rd_en = 1'b0;
    host_wdata = 8'h00;
  end

  // ==========================================================
  // Byte accesses
  // Released lines show the inverse of the last value, so stale data never looks valid
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1;
    host_addr = a;
    host_wdata = d;
    host_wr_en = 1'b1;
    @(posedge core_clk);
    #1;
    host_wr_en = 1'b0;
    host_addr = ~a;
    host_wdata = ~d;
  endtask

  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge core_clk);
    #1;
    host_addr = a;
    host_rd_en = 1'b1;
    @(posedge core_clk);
    #1;
    host_rd_en = 1'b0;
    host_addr = ~a;
    @(posedge core_clk);
    #1;
    d = host_rdata;
  endtask
endmodule
`default_nettype wire

// ==== test/compression_status_register_bank_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module compression_status_register_bank_tb;
  logic core_clk, nrst, byte_order_select, op_done, port_a_out_disabled, host_wr_en, host_rd_en;
  logic engine_cmd_valid, engine_paused;
  logic [4:0] host_addr;
  logic [7:0] host_wdata, host_rdata, fault_event, engine_cmd, port_a_fifo_control, command_high;
  logic [15:0] irq_event;
  logic [31:0] port_a_count, port_b_count, compressed_bytes, record_length, output_off_count, n;
  int failures, tests_run;

  cmp_status_regs dut (.core_clk(core_clk), .nrst(nrst), .host_addr(host_addr),
    .host_wr_en(host_wr_en), .host_rd_en(host_rd_en), .host_wdata(host_wdata),
    .byte_order_select(byte_order_select), .op_done(op_done), .fault_event(fault_event),
    .irq_event(irq_event), .port_a_out_disabled(port_a_out_disabled),
    .port_a_count(port_a_count), .port_b_count(port_b_count),
    .compressed_bytes(compressed_bytes), .host_rdata(host_rdata), .engine_cmd(engine_cmd),
    .engine_cmd_valid(engine_cmd_valid), .engine_paused(engine_paused),
    .record_length(record_length), .output_off_count(output_off_count),
    .port_a_fifo_control(port_a_fifo_control), .command_high(command_high));

  host_cpu_model cpu (.core_clk(core_clk), .host_addr(host_addr), .host_wr_en(host_wr_en),
    .host_rd_en(host_rd_en), .host_wdata(host_wdata), .host_rdata(host_rdata));

  // ==========================================================
  // Clock and helpers
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("Checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask

  task automatic rchk(input logic [4:0] a, input logic [7:0] e);
    logic [7:0] d;
    cpu.rd(a, d);
    check({24'h0, d}, {24'h0, e});
  endtask

  task automatic cmd(input logic [7:0] c);
    cpu.wr(cmp_status_pkg::OFF_COMMAND_LOW, c);
  endtask

  // Status reads go to the unswapped main status offset
  task automatic st(input logic [7:0] e);
    rchk(cmp_status_pkg::OFF_MAIN_STATUS, e);
  endtask

  // ==========================================================
  // Watchdog, sized well above the sequence length
  initial begin
    #(5 * 20000);
    failures++;
    stop_test;
  end

  // ==========================================================
  // Test sequence
  initial begin
    failures = 0;
    tests_run = 0;
    nrst = 1'b0;
    byte_order_select = 1'b0;
    op_done = 1'b0;
    fault_event = 8'h00;
    irq_event = 16'h0000;
    port_a_out_disabled = 1'b0;
    port_a_count = 32'h0;
    port_b_count = 32'h0;
    compressed_bytes = 32'h0;
    tick(10);
    nrst = 1'b1;
    tick(4);
    st(8'h00);
    rchk(cmp_status_pkg::OFF_COMMAND_HIGH, 8'h00);
    cpu.wr(5'h12, 8'h5a);
    rchk(5'h12, 8'h00);
    cpu.wr(cmp_status_pkg::OFF_MAIN_STATUS, 8'hff);
    st(8'h00);
    byte_order_select = 1'b1;
    cpu.wr(5'h17, 8'h3c);
    cpu.wr(5'h16, 8'hc3);
    byte_order_select = 1'b0;
    check(record_length, 32'h0000c33c);
    rchk(cmp_status_pkg::OFF_RECORD_LENGTH_BYTE0, 8'h3c);
    cpu.wr(cmp_status_pkg::OFF_OUTPUT_OFF_COUNT_BYTE3, 8'h7e);
    cpu.wr(cmp_status_pkg::OFF_FAULT_MASK, 8'h01);
    cpu.wr(cmp_status_pkg::OFF_IRQ_MASK_LOW, 8'h01);
    cmd(cmp_status_pkg::CMD_START_COMP_BYPASS);
    check({31'h0, engine_cmd_valid}, 32'h1);
    st(8'h90);
    check({24'h0, engine_cmd}, {24'h0, cmp_status_pkg::CMD_START_COMP_BYPASS});
    check({31'h0, engine_cmd_valid}, 32'h0);
    op_done = 1'b1;
    tick(1);
    op_done = 1'b0;
    st(8'h01);
    for (int k = 0; k < 3; k++) begin
      cmd(cmp_status_pkg::CMD_START_DECOMP_BYPASS);
      st(8'h90);
      cmd(k == 0 ? cmp_status_pkg::CMD_START_COMP :
          k == 1 ? cmp_status_pkg::CMD_START_DECOMP : cmp_status_pkg::CMD_START_DECOMP_OUT_OFF);
      st(8'h80);
    end
    cmd(cmp_status_pkg::CMD_START_COMP);
    port_b_count = 32'h10;
    port_a_count = 32'h8;
    st(8'h88);
    port_a_count = 32'h2000_0000;
    st(8'h80);
    fault_event = 8'h01;
    tick(1);
    fault_event = 8'h00;
    st(8'h02);
    rchk(cmp_status_pkg::OFF_FAULT_STATUS, 8'h01);
    cmd(cmp_status_pkg::CMD_START_DECOMP);
    st(8'h80);
    rchk(cmp_status_pkg::OFF_FAULT_STATUS, 8'h00);
    rchk(cmp_status_pkg::OFF_RECORD_LENGTH_BYTE0, 8'h3c);
    check(output_off_count, 32'h7e00_0000);
    // A pending unmasked irq pauses the transfer on its own
    irq_event = 16'h0001;
    tick(1);
    irq_event = 16'h0000;
    rchk(cmp_status_pkg::OFF_IRQ_STATUS_LOW, 8'h01);
    tick(45);
    st(8'hc4);
    cpu.wr(cmp_status_pkg::OFF_IRQ_STATUS_LOW, 8'h01);
    st(8'hc4);
    cmd(cmp_status_pkg::CMD_RESUME);
    st(8'h80);
    cmd(cmp_status_pkg::CMD_PAUSE);
    n = 32'h0;
    while (engine_paused !== 1'b1 && n < 32'd100) begin
      tick(1);
      n++;
    end
    check(n, 32'd40);
    port_a_out_disabled = 1'b1;
    st(8'he0);
    port_a_out_disabled = 1'b0;
    st(8'he0);
    cmd(cmp_status_pkg::CMD_RESUME);
    st(8'h80);
    cmd(cmp_status_pkg::CMD_PAUSE);
    tick(42);
    // Completion while paused: done sets, busy is held until resume or start
    op_done = 1'b1;
    tick(1);
    op_done = 1'b0;
    st(8'hc1);
    cmd(cmp_status_pkg::CMD_START_COMP);
    st(8'h80);
    port_b_count = 32'h1234;
    compressed_bytes = 32'h5678;
    tick(4);
    rchk(cmp_status_pkg::OFF_SHARED_LO, 8'h34);
    rchk(cmp_status_pkg::OFF_SHARED_HI, 8'h12);
    cmd(cmp_status_pkg::CMD_SEL_PORT_A);
    cpu.wr(cmp_status_pkg::OFF_SHARED_LO, 8'h5a);
    rchk(cmp_status_pkg::OFF_SHARED_LO, 8'h5a);
    rchk(cmp_status_pkg::OFF_SHARED_HI, 8'h00);
    st(8'h00);
    check({24'h0, port_a_fifo_control}, 32'h5a);
    cmd(cmp_status_pkg::CMD_SEL_PORT_B);
    rchk(cmp_status_pkg::OFF_SHARED_LO, 8'h78);
    byte_order_select = 1'b1;
    rchk(cmp_status_pkg::OFF_SHARED_LO, 8'h56);
    rchk(5'h11, cmp_status_pkg::CMD_SEL_PORT_B);
    byte_order_select = 1'b0;
    cmd(cmp_status_pkg::CMD_RESET);
    rchk(cmp_status_pkg::OFF_COMMAND_HIGH, 8'ha0);
    check({24'h0, command_high}, 32'ha0);
    check(output_off_count, 32'h0);
    rchk(cmp_status_pkg::OFF_RECORD_LENGTH_BYTE0, 8'h00);
    rchk(cmp_status_pkg::OFF_FAULT_MASK, 8'h00);
    st(8'h00);
    check({24'h0, port_a_fifo_control}, 32'h0);
    // Second hardware reset in mid-run
    nrst = 1'b0;
    tick(1);
    nrst = 1'b1;
    tick(4);
    rchk(cmp_status_pkg::OFF_COMMAND_HIGH, 8'h00);
    stop_test;
  end
endmodule
`default_nettype wire
